// >>> inc/bdm_map.svh
// Address map, field positions and reset values of the banked data memory
`ifndef BDM_MAP_SVH
`define BDM_MAP_SVH

// ==========================================================================
// Special area addresses
`define BDM_ADDR_PORT0    8'h00
`define BDM_ADDR_PTR0     8'h01
`define BDM_ADDR_PORT1    8'h02
`define BDM_ADDR_PTR1     8'h03
`define BDM_ADDR_BANK     8'h04
`define BDM_ADDR_ACC      8'h05
`define BDM_ADDR_PC_LOW   8'h06
`define BDM_ADDR_SFR_LAST 8'h33
`define BDM_ADDR_UNUSED_LO 8'h34
`define BDM_ADDR_UNUSED_HI 8'h3F
`define BDM_ADDR_NVC      8'h40
`define BDM_ADDR_RO_TABLE 8'h08

// ==========================================================================
// General purpose area, 32 bytes in each bank
`define BDM_GP_BASE       8'h60
`define BDM_GP_LAST       8'h7F
`define BDM_GP_WORDS      64

// ==========================================================================
// Fields and reset values
`define BDM_BANK_BIT      0
`define BDM_BANK_RESET    1'h0
`define BDM_BYTE_RESET    8'h00
`define BDM_READ_ZERO     8'h00

`endif

// >>> inc/bdm_pkg.sv
// Types of the banked data memory
package bdm_pkg;

    typedef logic [7:0] bdm_byte_t;

    // Where a resolved access lands
    typedef enum logic [3:0] {
        BDM_TGT_NONE,
        BDM_TGT_RAM,
        BDM_TGT_PTR0,
        BDM_TGT_PTR1,
        BDM_TGT_BANK,
        BDM_TGT_ACC,
        BDM_TGT_PC_LOW,
        BDM_TGT_SFR,
        BDM_TGT_NVC
    } bdm_target_t;

    typedef struct packed {
        logic [63:0][7:0] ram;
        bdm_byte_t        ptr0;
        bdm_byte_t        ptr1;
        logic             bank;
        bdm_byte_t        acc;
        bdm_byte_t        rdata;
        logic             rvalid;
        logic             jump_load;
        bdm_byte_t        jump_val;
        logic             dummy;
        logic             sfr_wr;
        bdm_byte_t        sfr_waddr;
        bdm_byte_t        sfr_wdata;
        logic             nvc_wr;
        bdm_byte_t        nvc_wdata;
    } bdm_state_t;

endpackage

// >>> design/bdm_data_memory.sv
// Banked data memory with direct and indirect addressing
//
// What this block does
// - Data memory is volatile and every location holds one 8-bit byte.
// - Two banks; port 1 indirect bank chosen by the bank selector register.
// - Special registers seen in any bank; nv control at 40H bank 1 only.
// - The data memory address space starts at location 00H.
// - 64 general purpose bytes over both banks, all read and write.
// - Bit set and clear change one chosen bit and keep the rest.
// - Unused special locations, including 34H to 3FH, read as 00H.
// - Read-only special registers ignore software writes.
// - Ports, pointers, bank, accumulator, counter low byte sit at 00H-06H.
// - Indirect port access goes to its pointer's location; no storage.
// - Port 0 reaches bank 0 only; port 1 reaches the selected bank.
// - Pointer naming a port: indirect read gives 00H, write does nothing.
// - Both pointers are ordinary read, write and modify registers.
// - Direct accesses always land in bank 0.
// - Bank bit 0 selects the bank; bits 7 to 1 read as zero.
// - Reset clears bank to 0, except watchdog reset in power-down.
// - ALU results go to the accumulator; moves pass through it.
// - Low counter byte write jumps within the page; one dummy cycle.
`timescale 1ns/1ps
`include "bdm_map.svh"

module bdm_data_memory (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_n_i,
    // Synchronous resets from the system controller
    input  wire logic       sync_reset_i,
    input  wire logic       wdt_pd_reset_i,
    // Core access request
    input  wire logic       req_valid_i,
    output logic            req_ready_o,
    input  wire logic       req_write_i,
    input  wire logic [7:0] req_addr_i,
    input  wire logic [7:0] req_wdata_i,
    input  wire logic       req_bitop_i,
    input  wire logic [2:0] req_bit_i,
    input  wire logic       req_bitval_i,
    // Read answer
    output logic            rd_valid_o,
    output logic [7:0]      rd_data_o,
    // ALU result path
    input  wire logic       alu_wr_i,
    input  wire logic [7:0] alu_data_i,
    output logic [7:0]      acc_o,
    // Program counter low byte
    input  wire logic [7:0] pc_low_i,
    output logic            pc_low_load_o,
    output logic [7:0]      pc_low_value_o,
    output logic            dummy_cycle_o,
    // Other special registers outside this block
    output logic [7:0]      sfr_raddr_o,
    input  wire logic [7:0] sfr_rdata_i,
    output logic            sfr_wr_o,
    output logic [7:0]      sfr_waddr_o,
    output logic [7:0]      sfr_wdata_o,
    // Non-volatile store control register
    input  wire logic [7:0] nvc_rdata_i,
    output logic            nvc_wr_o,
    output logic [7:0]      nvc_wdata_o,
    // Bank state
    output logic            bank_sel_o
);

    // ======================================================================
    // State
    bdm_pkg::bdm_state_t s_q;
    bdm_pkg::bdm_state_t s_d;

    bdm_pkg::bdm_target_t tgt;
    logic [7:0]           eff_addr;
    logic                 eff_bank;
    logic                 indirect;
    logic [5:0]           ram_idx;
    logic [7:0]           rv;
    logic [7:0]           wv;
    logic                 take;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    // ======================================================================
    // Handshake
    // stall for load and dummy
    assign req_ready_o = !(s_q.jump_load || s_q.dummy);
    assign take        = req_valid_i && req_ready_o;

    // ======================================================================
    // Address resolution
    always_comb begin
        indirect = 1'b0;
        eff_addr = req_addr_i;
        eff_bank = 1'b0;
        if (req_addr_i == `BDM_ADDR_PORT0) begin
            indirect = 1'b1;
            // port 0 fixed to bank 0
            eff_addr = s_q.ptr0;
            eff_bank = 1'b0;
        end else if (req_addr_i == `BDM_ADDR_PORT1) begin
            indirect = 1'b1;
            eff_addr = s_q.ptr1;
            eff_bank = s_q.bank;
        end else begin
            eff_bank = 1'b0;
        end
    end

    assign ram_idx = {eff_bank, eff_addr[4:0]};

    always_comb begin
        tgt = bdm_pkg::BDM_TGT_NONE;
        if (eff_addr <= `BDM_ADDR_SFR_LAST) begin
            case (eff_addr)
                // pointer at a port is a dead location
                `BDM_ADDR_PORT0: tgt = bdm_pkg::BDM_TGT_NONE;
                `BDM_ADDR_PORT1: tgt = bdm_pkg::BDM_TGT_NONE;
                `BDM_ADDR_PTR0:  tgt = bdm_pkg::BDM_TGT_PTR0;
                `BDM_ADDR_PTR1:  tgt = bdm_pkg::BDM_TGT_PTR1;
                `BDM_ADDR_BANK:  tgt = bdm_pkg::BDM_TGT_BANK;
                `BDM_ADDR_ACC:   tgt = bdm_pkg::BDM_TGT_ACC;
                `BDM_ADDR_PC_LOW: tgt = bdm_pkg::BDM_TGT_PC_LOW;
                default:         tgt = bdm_pkg::BDM_TGT_SFR;
            endcase
        // nv control only in bank 1
        end else if (eff_addr == `BDM_ADDR_NVC && eff_bank) begin
            tgt = bdm_pkg::BDM_TGT_NVC;
        end else if (eff_addr >= `BDM_GP_BASE &&
                     eff_addr <= `BDM_GP_LAST) begin
            tgt = bdm_pkg::BDM_TGT_RAM;
        end
    end

    // ======================================================================
    // Read value of the resolved location
    always_comb begin
        case (tgt)
            bdm_pkg::BDM_TGT_RAM:  rv = s_q.ram[ram_idx];
            bdm_pkg::BDM_TGT_PTR0: rv = s_q.ptr0;
            bdm_pkg::BDM_TGT_PTR1: rv = s_q.ptr1;
            bdm_pkg::BDM_TGT_BANK: rv = {7'h00, s_q.bank};
            bdm_pkg::BDM_TGT_ACC:  rv = s_q.acc;
            bdm_pkg::BDM_TGT_PC_LOW: rv = pc_low_i;
            bdm_pkg::BDM_TGT_SFR:  rv = sfr_rdata_i;
            bdm_pkg::BDM_TGT_NVC:  rv = nvc_rdata_i;
            default:               rv = `BDM_READ_ZERO;
        endcase
    end

    // single bit merged into old byte
    always_comb begin
        wv = req_wdata_i;
        if (req_bitop_i) begin
            wv = rv;
            wv[req_bit_i] = req_bitval_i;
        end
    end

    assign sfr_raddr_o = eff_addr;

    // ======================================================================
    // Next state
    always_comb begin
        s_d          = s_q;
        s_d.rvalid   = 1'b0;
        s_d.jump_load = 1'b0;
        s_d.dummy     = s_q.jump_load;
        s_d.sfr_wr   = 1'b0;
        s_d.nvc_wr   = 1'b0;
        if (take && !req_write_i) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rv;
        end
        if (take && req_write_i) begin
            case (tgt)
                bdm_pkg::BDM_TGT_RAM:  s_d.ram[ram_idx] = wv;
                bdm_pkg::BDM_TGT_PTR0: s_d.ptr0 = wv;
                bdm_pkg::BDM_TGT_PTR1: s_d.ptr1 = wv;
                bdm_pkg::BDM_TGT_BANK: s_d.bank = wv[`BDM_BANK_BIT];
                bdm_pkg::BDM_TGT_ACC:  s_d.acc = wv;
                bdm_pkg::BDM_TGT_PC_LOW: begin
                    s_d.jump_load = 1'b1;
                    s_d.jump_val  = wv;
                end
                bdm_pkg::BDM_TGT_SFR: begin
                    s_d.sfr_wr    = (eff_addr != `BDM_ADDR_RO_TABLE);
                    s_d.sfr_waddr = eff_addr;
                    s_d.sfr_wdata = wv;
                end
                bdm_pkg::BDM_TGT_NVC: begin
                    s_d.nvc_wr    = 1'b1;
                    s_d.nvc_wdata = wv;
                end
                default: ;
            endcase
        end
        if (alu_wr_i) begin
            s_d.acc = alu_data_i;
        end
        // bank kept on power-down watchdog reset
        if (sync_reset_i && !wdt_pd_reset_i) begin
            s_d.bank = `BDM_BANK_RESET;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // Outputs
    assign rd_valid_o     = s_q.rvalid;
    assign rd_data_o      = s_q.rdata;
    assign acc_o          = s_q.acc;
    assign pc_low_load_o  = s_q.jump_load;
    assign pc_low_value_o = s_q.jump_val;
    assign dummy_cycle_o  = s_q.dummy;
    assign sfr_wr_o       = s_q.sfr_wr;
    assign sfr_waddr_o    = s_q.sfr_waddr;
    assign sfr_wdata_o    = s_q.sfr_wdata;
    assign nvc_wr_o       = s_q.nvc_wr;
    assign nvc_wdata_o    = s_q.nvc_wdata;
    assign bank_sel_o     = s_q.bank;

    // ======================================================================
    // Checks
    logic rd_take;
    logic wr_take;
    assign rd_take = take && !req_write_i;
    assign wr_take = take && req_write_i;

    sequence s_jump_write;
        wr_take && req_addr_i == `BDM_ADDR_PC_LOW;
    endsequence

    sequence s_load_then_dummy;
        pc_low_load_o && !dummy_cycle_o ##1 dummy_cycle_o && !pc_low_load_o;
    endsequence

    sequence s_stalled_two;
        !req_ready_o [*2] ##1 req_ready_o;
    endsequence

    // load pulse then one dummy cycle
    a_jump_seq: assert property (
        s_jump_write |=> s_load_then_dummy)
        else $error("counter low write did not load then dummy");

    // requests refused over load and dummy
    a_jump_stall: assert property (
        s_jump_write |=> s_stalled_two)
        else $error("core not stalled for exactly two cycles");

    // plain sync reset returns bank 0
    a_bank_reset: assert property (
        sync_reset_i && !wdt_pd_reset_i |=> !bank_sel_o)
        else $error("bank not cleared by reset");

    a_bank_keep: assert property (
        sync_reset_i && wdt_pd_reset_i && !wr_take |=> $stable(bank_sel_o))
        else $error("bank changed on power-down watchdog reset");

    a_unused_zero: assert property (
        rd_take && req_addr_i >= `BDM_ADDR_UNUSED_LO
        && req_addr_i <= `BDM_ADDR_UNUSED_HI
        |=> rd_valid_o && rd_data_o == `BDM_READ_ZERO)
        else $error("unused location read not zero");

    // port 1 pointer naming a port reads zero
    a_port_loop: assert property (
        rd_take && req_addr_i == `BDM_ADDR_PORT1
        && (s_q.ptr1 == `BDM_ADDR_PORT0 || s_q.ptr1 == `BDM_ADDR_PORT1)
        |=> rd_data_o == `BDM_READ_ZERO)
        else $error("indirect read of a port not zero");

    // direct GP write lands in bank 0
    a_direct_bank0: assert property (
        wr_take && !req_bitop_i && req_addr_i >= `BDM_GP_BASE
        && req_addr_i <= `BDM_GP_LAST
        |=> s_q.ram[{1'b0, $past(req_addr_i[4:0])}] == $past(req_wdata_i))
        else $error("direct write missed bank 0");

    // port 1 writes into selected bank
    a_port1_bank: assert property (
        wr_take && !req_bitop_i && req_addr_i == `BDM_ADDR_PORT1
        && s_q.ptr1 >= `BDM_GP_BASE && s_q.ptr1 <= `BDM_GP_LAST
        |=> s_q.ram[{$past(s_q.bank), $past(s_q.ptr1[4:0])}]
            == $past(req_wdata_i))
        else $error("port 1 write went to wrong bank");

    // bank readback has zero upper bits
    a_bank_rdback: assert property (
        rd_take && req_addr_i == `BDM_ADDR_BANK
        |=> rd_data_o == {7'h00, $past(bank_sel_o)})
        else $error("bank readback wrong");

    a_ro_write: assert property (
        wr_take && req_addr_i == `BDM_ADDR_RO_TABLE |=> !sfr_wr_o)
        else $error("write forwarded to read-only register");

    a_bitop_keep: assert property (
        wr_take && req_bitop_i && tgt == bdm_pkg::BDM_TGT_RAM
        && !sync_reset_i
        |=> s_q.ram[$past(ram_idx)] ==
            (($past(rv) & ~(8'h01 << $past(req_bit_i)))
             | ({7'h00, $past(req_bitval_i)} << $past(req_bit_i))))
        else $error("bit operation disturbed other bits");

    // nv control silent in bank 0
    a_nvc_bank1: assert property (
        nvc_wr_o |-> $past(eff_bank) && $past(eff_addr) == `BDM_ADDR_NVC)
        else $error("nv control written outside bank 1");

    a_acc_alu: assert property (
        alu_wr_i |=> acc_o == $past(alu_data_i))
        else $error("accumulator missed ALU result");

endmodule

// >>> verif/bdm_sfr_model.sv
// Model of the special registers that sit outside the data memory block
`timescale 1ns/1ps

module bdm_sfr_model (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_n_i,
    // Special register access
    input  wire logic [7:0] sfr_raddr_i,
    output logic [7:0]      sfr_rdata_o,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_waddr_i,
    input  wire logic [7:0] sfr_wdata_i,
    // Non-volatile store control
    output logic [7:0]      nvc_rdata_o,
    input  wire logic       nvc_wr_i,
    input  wire logic [7:0] nvc_wdata_i
);
    logic [7:0] regs_q [8'h07:8'h33];
    logic [3:0] nvc_q;

    // Places outside the table answer zero
    always_comb begin
        sfr_rdata_o = 8'h00;
        if (sfr_raddr_i >= 8'h07 && sfr_raddr_i <= 8'h33) begin
            sfr_rdata_o = regs_q[sfr_raddr_i];
        end
    end
    // Upper control bits unimplemented
    assign nvc_rdata_o = {4'h0, nvc_q};

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 8'h07; i <= 8'h33; i++) begin
                regs_q[i] <= 8'(i) ^ 8'h5A;
            end
            nvc_q <= 4'h0;
        end else begin
            // Read-only table byte ignores writes
            if (sfr_wr_i && sfr_waddr_i != 8'h08) begin
                regs_q[sfr_waddr_i] <= sfr_wdata_i;
            end
            if (nvc_wr_i) begin
                nvc_q <= nvc_wdata_i[3:0];
            end
        end
    end
endmodule

// >>> verif/banked_data_memory_addressing_tb_top.sv
// Self-checking bench of the banked data memory
`timescale 1ns/1ps

module banked_data_memory_addressing_tb_top;
    logic       clock_i, reset_n_i, sync_reset_i, wdt_pd_reset_i;
    logic       req_valid_i, req_ready_o, req_write_i, req_bitop_i;
    logic [7:0] req_addr_i, req_wdata_i, rd_data_o, acc_o, alu_data_i;
    logic [2:0] req_bit_i;
    logic       req_bitval_i, rd_valid_o, alu_wr_i, pc_low_load_o;
    logic [7:0] pc_low_i, pc_low_value_o, sfr_raddr_o, sfr_rdata_i;
    logic [7:0] sfr_waddr_o, sfr_wdata_o, nvc_rdata_i, nvc_wdata_o;
    logic       dummy_cycle_o, sfr_wr_o, nvc_wr_o, bank_sel_o;
    logic       p_rv, p_sfr, p_nvc, p_pcl, p_rdy;
    logic [7:0] p_rd;
    int         errors, check_count;

    bdm_data_memory DUT (
        .clock_i, .reset_n_i, .sync_reset_i, .wdt_pd_reset_i,
        .req_valid_i, .req_ready_o, .req_write_i, .req_addr_i,
        .req_wdata_i, .req_bitop_i, .req_bit_i, .req_bitval_i,
        .rd_valid_o, .rd_data_o, .alu_wr_i, .alu_data_i, .acc_o,
        .pc_low_i, .pc_low_load_o, .pc_low_value_o, .dummy_cycle_o,
        .sfr_raddr_o, .sfr_rdata_i, .sfr_wr_o, .sfr_waddr_o,
        .sfr_wdata_o, .nvc_rdata_i, .nvc_wr_o, .nvc_wdata_o,
        .bank_sel_o
    );

    bdm_sfr_model u_sfr (
        .clock_i, .reset_n_i,
        .sfr_raddr_i(sfr_raddr_o), .sfr_rdata_o(sfr_rdata_i),
        .sfr_wr_i(sfr_wr_o), .sfr_waddr_i(sfr_waddr_o),
        .sfr_wdata_i(sfr_wdata_o), .nvc_rdata_o(nvc_rdata_i),
        .nvc_wr_i(nvc_wr_o), .nvc_wdata_i(nvc_wdata_o)
    );

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // ======================================================
    // Checks and bus tasks
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Starts and ends on a rising edge; request held until taken
    task automatic access(input logic w, input logic [7:0] a, d,
                          input logic bo = 1'b0, input logic [2:0] b = 3'h0);
        int n;
        n = 0;
        req_valid_i <= 1'b1;
        req_write_i <= w;
        req_addr_i <= a;
        req_wdata_i <= d;
        req_bitval_i <= d[0];
        req_bitop_i <= bo;
        req_bit_i <= b;
        @(negedge clock_i);
        while (req_ready_o !== 1'b1) begin
            n++;
            if (n > 20) begin
                errors++;
                $display("ERROR ready expected 1 seen %b", req_ready_o);
                complete_run();
            end
            @(negedge clock_i);
        end
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        req_bitop_i <= 1'b0;
        @(negedge clock_i);
        p_rv = rd_valid_o;
        p_rd = rd_data_o;
        p_sfr = sfr_wr_o;
        p_nvc = nvc_wr_o;
        p_pcl = pc_low_load_o;
        p_rdy = req_ready_o;
        @(posedge clock_i);
    endtask

    task automatic wr(input logic [7:0] a, d);
        access(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, exp);
        access(1'b0, a, 8'h00);
        chk("rd_valid", 8'h01, {7'h00, p_rv});
        chk($sformatf("read %h", a), exp, p_rd);
    endtask

    // ======================================================
    // Main sequence
    logic [7:0] unused [6] = '{8'h34, 8'h3F, 8'h40, 8'h50, 8'h80, 8'hFF};

    initial begin
        {reset_n_i, sync_reset_i, wdt_pd_reset_i, req_valid_i} = 4'h0;
        {req_write_i, req_bitop_i, req_bitval_i, alu_wr_i} = 4'h0;
        {req_addr_i, req_wdata_i, alu_data_i} = 24'h000000;
        req_bit_i = 3'h0;
        pc_low_i = 8'h37;
        repeat (6) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        rd(8'h04, 8'h00);
        rd(8'h60, 8'h00);
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'h01);
        chk("bank_sel", 8'h01, {7'h00, bank_sel_o});
        wr(8'h60, 8'hA5);
        wr(8'h7F, 8'h3C);
        wr(8'h03, 8'h60);
        rd(8'h03, 8'h60);
        rd(8'h02, 8'h00);
        wr(8'h02, 8'h5A);
        rd(8'h60, 8'hA5);
        rd(8'h02, 8'h5A);
        wr(8'h04, 8'h00);
        rd(8'h02, 8'hA5);
        wr(8'h04, 8'h01);
        wr(8'h01, 8'h7F);
        rd(8'h00, 8'h3C);
        wr(8'h00, 8'hC3);
        rd(8'h7F, 8'hC3);
        rd(8'h01, 8'h7F);
        wr(8'h01, 8'h02);
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h11);
        rd(8'h02, 8'h5A);
        wr(8'h03, 8'h02);
        rd(8'h02, 8'h00);
        wr(8'h02, 8'h77);
        rd(8'h03, 8'h02);
        access(1'b1, 8'h60, 8'h01, 1'b1, 3'h3);
        rd(8'h60, 8'hAD);
        access(1'b1, 8'h60, 8'h00, 1'b1, 3'h0);
        rd(8'h60, 8'hAC);
        foreach (unused[i]) rd(unused[i], 8'h00);
        wr(8'h03, 8'h40);
        wr(8'h02, 8'h0B);
        chk("nvc_wr", 8'h01, {7'h00, p_nvc});
        chk("nvc_wdata", 8'h0B, nvc_wdata_o);
        rd(8'h02, 8'h0B);
        wr(8'h04, 8'h00);
        rd(8'h02, 8'h00);
        wr(8'h07, 8'h66);
        chk("sfr_wr", 8'h01, {7'h00, p_sfr});
        chk("sfr_waddr", 8'h07, sfr_waddr_o);
        chk("sfr_wdata", 8'h66, sfr_wdata_o);
        rd(8'h07, 8'h66);
        wr(8'h08, 8'h99);
        chk("sfr_wr", 8'h00, {7'h00, p_sfr});
        rd(8'h08, 8'h52);
        wr(8'h05, 8'h12);
        rd(8'h05, 8'h12);
        alu_wr_i <= 1'b1;
        alu_data_i <= 8'h9C;
        @(posedge clock_i);
        alu_wr_i <= 1'b0;
        rd(8'h05, 8'h9C);
        chk("acc", 8'h9C, acc_o);
        rd(8'h06, 8'h37);
        wr(8'h06, 8'hE4);
        chk("pc_load", 8'h01, {7'h00, p_pcl});
        chk("ready", 8'h00, {7'h00, p_rdy});
        chk("pc_value", 8'hE4, pc_low_value_o);
        @(negedge clock_i);
        chk("dummy", 8'h01, {7'h00, dummy_cycle_o});
        chk("ready", 8'h00, {7'h00, req_ready_o});
        @(negedge clock_i);
        chk("ready", 8'h01, {7'h00, req_ready_o});
        @(posedge clock_i);
        wr(8'h04, 8'h01);
        sync_reset_i <= 1'b1;
        wdt_pd_reset_i <= 1'b1;
        @(posedge clock_i);
        sync_reset_i <= 1'b0;
        wdt_pd_reset_i <= 1'b0;
        @(negedge clock_i);
        chk("bank_sel", 8'h01, {7'h00, bank_sel_o});
        @(posedge clock_i);
        sync_reset_i <= 1'b1;
        @(posedge clock_i);
        sync_reset_i <= 1'b0;
        @(negedge clock_i);
        chk("bank_sel", 8'h00, {7'h00, bank_sel_o});
        @(posedge clock_i);
        rd(8'h04, 8'h00);
        complete_run();
    end
endmodule
